// [sea_pkg.sv]
package sea_pkg;

    // Register and data widths
    localparam int REG_W = 16;
    localparam int SEL_W = 4;
    localparam int RAW_W = 17;

    // Command operations taken on the command port
    typedef enum logic [1:0]
    {
        SEA_OP_READ = 2'h0,
        SEA_OP_WRITE = 2'h1,
        SEA_OP_PRESET = 2'h3,
        SEA_OP_PROT_CLEAR = 2'h2
    } sea_op_t;

    // Register select: bit 3 picks the group, bits 2..0 the register
    localparam logic [SEL_W-1:0] SEL_GROUP_BIT = 4'h8;
    localparam logic [2:0] REG_EVENT = 3'h0;
    localparam logic [2:0] REG_COND = 3'h1;
    localparam logic [2:0] REG_MASK = 3'h2;
    localparam logic [2:0] REG_FALL = 3'h3;
    localparam logic [2:0] REG_RISE = 3'h4;
    localparam logic [SEL_W-1:0] SEL_OVP_STATE = 4'h5;

    // Legal write range and preset values
    localparam logic [REG_W-1:0] FILTER_MAX = 16'h7FFF;
    localparam logic [REG_W-1:0] PRESET_FALL = 16'h0000;
    localparam logic [REG_W-1:0] PRESET_RISE = 16'h7FFF;
    localparam logic [REG_W-1:0] PRESET_MASK = 16'h0000;
    localparam logic [REG_W-1:0] EVENT_RESET = 16'h0000;

    // Operation condition bit positions
    localparam int OPERATION_SUMMARY_BIT_CAL = 0;
    localparam int OPERATION_SUMMARY_BIT_WAIT_TRIG = 5;
    localparam int OPERATION_SUMMARY_BIT_CV_MAIN = 8;
    localparam int OPERATION_SUMMARY_BIT_CV_SECOND = 9;
    localparam int OPERATION_SUMMARY_BIT_CC_POS = 10;
    localparam int OPERATION_SUMMARY_BIT_CC_NEG = 11;
    localparam int OPERATION_SUMMARY_BIT_CC_SECOND = 12;
    localparam logic [REG_W-1:0] OPERATION_SUMMARY_BIT_DEFINED = 16'h1F21;

    // Questionable condition bit positions
    localparam int QUESTIONABLE_SUMMARY_BIT_OV = 0;
    localparam int QUESTIONABLE_SUMMARY_BIT_OC = 1;
    localparam int QUESTIONABLE_SUMMARY_BIT_LOCAL_KEY = 3;
    localparam int QUESTIONABLE_SUMMARY_BIT_OT = 4;
    localparam int QUESTIONABLE_SUMMARY_BIT_OPEN_SENSE = 5;
    localparam int QUESTIONABLE_SUMMARY_BIT_UNREG_SECOND = 8;
    localparam int QUESTIONABLE_SUMMARY_BIT_INHIBIT = 9;
    localparam int QUESTIONABLE_SUMMARY_BIT_UNREG_MAIN = 10;
    localparam int QUESTIONABLE_SUMMARY_BIT_OC_SECOND = 12;
    localparam int QUESTIONABLE_SUMMARY_BIT_MEAS_OVLD = 14;
    localparam logic [REG_W-1:0] QUESTIONABLE_SUMMARY_BIT_DEFINED = 16'h573B;

    // Positions of the raw status pins in the synchroniser vector
    localparam int IN_CAL = 0;
    localparam int IN_WAIT_TRIG = 1;
    localparam int IN_CV_MAIN = 2;
    localparam int IN_CV_SECOND = 3;
    localparam int IN_CC_POS = 4;
    localparam int IN_CC_NEG = 5;
    localparam int IN_CC_SECOND = 6;
    localparam int IN_OV_SENSE = 7;
    localparam int IN_OC = 8;
    localparam int IN_LOCAL_KEY = 9;
    localparam int IN_OT = 10;
    localparam int IN_OPEN_SENSE = 11;
    localparam int IN_UNREG_SECOND = 12;
    localparam int IN_INHIBIT = 13;
    localparam int IN_UNREG_MAIN = 14;
    localparam int IN_OC_SECOND = 15;
    localparam int IN_MEAS_OVLD = 16;

endpackage

// [sea_sync.sv]
`timescale 1ns/10ps

module sea_sync
#(
    parameter int W = 1
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Raw pins and settled levels
    input wire logic [W-1:0] raw,
    output logic [W-1:0] settled
);
    import sea_pkg::*;

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    ////////////////////////////////////////////////////////////////////////////
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            // Four flops; a change counts only once stages two and three agree
            always_ff @(posedge clock)
            begin
                if (srst)
                begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                    stage3[i] <= 1'b0;
                    settled[i] <= 1'b0;
                end
                else
                begin
                    stage1[i] <= raw[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    if (stage2[i] == stage3[i])
                        settled[i] <= stage3[i]; // Filters a one-cycle glitch
                end
            end
        end
    endgenerate

endmodule

// [sea_group.sv]
`timescale 1ns/10ps

module sea_group
#(
    parameter logic [15:0] DEFINED = 16'h0000
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Live condition and filters
    input wire logic [sea_pkg::REG_W-1:0] cond,
    input wire logic [sea_pkg::REG_W-1:0] fall_sel,
    input wire logic [sea_pkg::REG_W-1:0] rise_sel,
    input wire logic [sea_pkg::REG_W-1:0] mask,
    // Event read strobe
    input wire logic event_read,
    // Latched events and summary bit
    output logic [sea_pkg::REG_W-1:0] event_latch,
    output logic summary
);
    import sea_pkg::*;

    logic [REG_W-1:0] cond_prev;
    logic [REG_W-1:0] passed;
    logic [REG_W-1:0] next_event;

    ////////////////////////////////////////////////////////////////////////////
    // Edge filter; undefined positions can never pass
    assign passed = ((~cond_prev & cond & rise_sel) | (cond_prev & ~cond & fall_sel))
                    & DEFINED;
    // A read clears, but an edge in the same cycle survives
    assign next_event = (event_latch & ~{REG_W{event_read}}) | passed;

    // Previous-cycle copy of the condition
    always_ff @(posedge clock)
    begin
        if (srst)
            cond_prev <= '0;
        else
            cond_prev <= cond;
    end

    // Sticky event bits
    always_ff @(posedge clock)
    begin
        if (srst)
            event_latch <= EVENT_RESET;
        else
            event_latch <= next_event;
    end

    // Summary follows the enabled events on the same edge that latches them
    always_ff @(posedge clock)
    begin
        if (srst)
            summary <= 1'b0;
        else
            summary <= |(next_event & mask);
    end

endmodule

// [sea_top.sv]
`timescale 1ns/10ps

module sea_top
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Status command port
    input wire logic cmd_valid,
    input wire sea_pkg::sea_op_t cmd_op,
    input wire logic [sea_pkg::SEL_W-1:0] cmd_sel,
    input wire logic [sea_pkg::REG_W-1:0] cmd_wdata,
    // Command answer
    output logic rsp_valid,
    output logic rsp_error,
    output logic [sea_pkg::REG_W-1:0] rsp_data,
    // Operation status pins
    input wire logic calibration_busy_flag,
    input wire logic awaiting_trigger_flag,
    input wire logic main_voltage_regulation_flag,
    input wire logic second_voltage_regulation_flag,
    input wire logic positive_current_regulation_flag,
    input wire logic negative_current_regulation_flag,
    input wire logic second_current_regulation_flag,
    // Questionable status pins
    input wire logic overvoltage_sense,
    input wire logic overcurrent_trip_flag,
    input wire logic local_key_flag,
    input wire logic overtemperature_trip_flag,
    input wire logic open_sense_lead_flag,
    input wire logic second_output_unregulated_flag,
    input wire logic inhibit_active_flag,
    input wire logic main_output_unregulated_flag,
    input wire logic second_overcurrent_trip_flag,
    input wire logic measurement_overload_flag,
    // Status byte summary bits and output control
    output logic operation_summary_bit,
    output logic questionable_summary_bit,
    output logic output_enable
);
    import sea_pkg::*;

    // Synchronised pins
    logic [RAW_W-1:0] raw_pins;
    logic [RAW_W-1:0] pins;

    // Condition registers
    logic [REG_W-1:0] operation_live_condition;
    logic [REG_W-1:0] questionable_live_condition;
    logic [REG_W-1:0] next_operation_summary_bit_cond;
    logic [REG_W-1:0] next_questionable_summary_bit_cond;

    // Software registers
    logic [REG_W-1:0] operation_summary_mask;
    logic [REG_W-1:0] operation_falling_edge_select;
    logic [REG_W-1:0] operation_rising_edge_select;
    logic [REG_W-1:0] questionable_summary_mask;
    logic [REG_W-1:0] questionable_falling_edge_select;
    logic [REG_W-1:0] questionable_rising_edge_select;
    logic ovp_enable;
    logic ovp_tripped;

    // Event latches
    logic [REG_W-1:0] operation_event_latch;
    logic [REG_W-1:0] questionable_event_latch;
    logic operation_summary_bit_summary_q;
    logic questionable_summary_bit_summary_q;

    // Command decode
    logic is_read;
    logic is_write;
    logic is_preset;
    logic is_prot_clear;
    logic sel_questionable_summary_bit;
    logic [2:0] sel_reg;
    logic sel_ovp;
    logic wdata_ok;
    logic wr_mask;
    logic wr_fall;
    logic wr_rise;
    logic rd_operation_summary_bit_event;
    logic rd_questionable_summary_bit_event;
    logic next_error;
    logic [REG_W-1:0] next_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Pin bundle for the synchroniser
    always_comb
    begin
        raw_pins = '0;
        raw_pins[IN_CAL] = calibration_busy_flag;
        raw_pins[IN_WAIT_TRIG] = awaiting_trigger_flag;
        raw_pins[IN_CV_MAIN] = main_voltage_regulation_flag;
        raw_pins[IN_CV_SECOND] = second_voltage_regulation_flag;
        raw_pins[IN_CC_POS] = positive_current_regulation_flag;
        raw_pins[IN_CC_NEG] = negative_current_regulation_flag;
        raw_pins[IN_CC_SECOND] = second_current_regulation_flag;
        raw_pins[IN_OV_SENSE] = overvoltage_sense;
        raw_pins[IN_OC] = overcurrent_trip_flag;
        raw_pins[IN_LOCAL_KEY] = local_key_flag;
        raw_pins[IN_OT] = overtemperature_trip_flag;
        raw_pins[IN_OPEN_SENSE] = open_sense_lead_flag;
        raw_pins[IN_UNREG_SECOND] = second_output_unregulated_flag;
        raw_pins[IN_INHIBIT] = inhibit_active_flag;
        raw_pins[IN_UNREG_MAIN] = main_output_unregulated_flag;
        raw_pins[IN_OC_SECOND] = second_overcurrent_trip_flag;
        raw_pins[IN_MEAS_OVLD] = measurement_overload_flag;
    end

    // Status pins come from the analog side, so they are resynchronised
    sea_sync #(.W(RAW_W)) u_sync
    (
        .clock(clock),
        .srst(srst),
        .raw(raw_pins),
        .settled(pins)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Operation condition map; unused positions stay zero
    always_comb
    begin
        next_operation_summary_bit_cond = '0;
        next_operation_summary_bit_cond[OPERATION_SUMMARY_BIT_CAL] = pins[IN_CAL];
        next_operation_summary_bit_cond[OPERATION_SUMMARY_BIT_WAIT_TRIG] = pins[IN_WAIT_TRIG];
        next_operation_summary_bit_cond[OPERATION_SUMMARY_BIT_CV_MAIN] = pins[IN_CV_MAIN];
        next_operation_summary_bit_cond[OPERATION_SUMMARY_BIT_CV_SECOND] = pins[IN_CV_SECOND];
        next_operation_summary_bit_cond[OPERATION_SUMMARY_BIT_CC_POS] = pins[IN_CC_POS];
        next_operation_summary_bit_cond[OPERATION_SUMMARY_BIT_CC_NEG] = pins[IN_CC_NEG];
        next_operation_summary_bit_cond[OPERATION_SUMMARY_BIT_CC_SECOND] = pins[IN_CC_SECOND];
    end

    // Questionable condition map; overvoltage shows the latched trip
    always_comb
    begin
        next_questionable_summary_bit_cond = '0;
        next_questionable_summary_bit_cond[QUESTIONABLE_SUMMARY_BIT_OV] = ovp_tripped;
        next_questionable_summary_bit_cond[QUESTIONABLE_SUMMARY_BIT_OC] = pins[IN_OC];
        next_questionable_summary_bit_cond[QUESTIONABLE_SUMMARY_BIT_LOCAL_KEY] = pins[IN_LOCAL_KEY];
        next_questionable_summary_bit_cond[QUESTIONABLE_SUMMARY_BIT_OT] = pins[IN_OT];
        next_questionable_summary_bit_cond[QUESTIONABLE_SUMMARY_BIT_OPEN_SENSE] = pins[IN_OPEN_SENSE];
        next_questionable_summary_bit_cond[QUESTIONABLE_SUMMARY_BIT_UNREG_SECOND] = pins[IN_UNREG_SECOND];
        next_questionable_summary_bit_cond[QUESTIONABLE_SUMMARY_BIT_INHIBIT] = pins[IN_INHIBIT];
        next_questionable_summary_bit_cond[QUESTIONABLE_SUMMARY_BIT_UNREG_MAIN] = pins[IN_UNREG_MAIN];
        next_questionable_summary_bit_cond[QUESTIONABLE_SUMMARY_BIT_OC_SECOND] = pins[IN_OC_SECOND];
        next_questionable_summary_bit_cond[QUESTIONABLE_SUMMARY_BIT_MEAS_OVLD] = pins[IN_MEAS_OVLD];
    end

    // Condition registers track the settled pins every cycle
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            operation_live_condition <= '0;
            questionable_live_condition <= '0;
        end
        else
        begin
            operation_live_condition <= next_operation_summary_bit_cond;
            questionable_live_condition <= next_questionable_summary_bit_cond;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command decode
    assign is_read = cmd_valid && (cmd_op == SEA_OP_READ);
    assign is_write = cmd_valid && (cmd_op == SEA_OP_WRITE);
    assign is_preset = cmd_valid && (cmd_op == SEA_OP_PRESET);
    assign is_prot_clear = cmd_valid && (cmd_op == SEA_OP_PROT_CLEAR);
    assign sel_questionable_summary_bit = (cmd_sel & SEL_GROUP_BIT) != '0;
    assign sel_reg = cmd_sel[2:0];
    assign sel_ovp = (cmd_sel == SEL_OVP_STATE);
    // Values above the documented range are refused, not truncated
    assign wdata_ok = (cmd_wdata <= FILTER_MAX);
    assign wr_mask = is_write && wdata_ok && (sel_reg == REG_MASK);
    assign wr_fall = is_write && wdata_ok && (sel_reg == REG_FALL);
    assign wr_rise = is_write && wdata_ok && (sel_reg == REG_RISE);
    // Only an event read has a side effect; condition reads change nothing
    assign rd_operation_summary_bit_event = is_read && !sel_questionable_summary_bit && (sel_reg == REG_EVENT);
    assign rd_questionable_summary_bit_event = is_read && sel_questionable_summary_bit && (sel_reg == REG_EVENT);

    ////////////////////////////////////////////////////////////////////////////
    // Operation-side writable registers; preset restores filters and mask
    always_ff @(posedge clock)
    begin
        if (srst || is_preset)
        begin
            operation_summary_mask <= PRESET_MASK;
            operation_falling_edge_select <= PRESET_FALL;
            operation_rising_edge_select <= PRESET_RISE;
        end
        else if (!sel_questionable_summary_bit && !sel_ovp)
        begin
            if (wr_mask)
                operation_summary_mask <= cmd_wdata;
            if (wr_fall)
                operation_falling_edge_select <= cmd_wdata;
            if (wr_rise)
                operation_rising_edge_select <= cmd_wdata;
        end
    end

    // Questionable-side writable registers
    always_ff @(posedge clock)
    begin
        if (srst || is_preset)
        begin
            questionable_summary_mask <= PRESET_MASK;
            questionable_falling_edge_select <= PRESET_FALL;
            questionable_rising_edge_select <= PRESET_RISE;
        end
        else if (sel_questionable_summary_bit)
        begin
            if (wr_mask)
                questionable_summary_mask <= cmd_wdata;
            if (wr_fall)
                questionable_falling_edge_select <= cmd_wdata;
            if (wr_rise)
                questionable_rising_edge_select <= cmd_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overvoltage protection enable, off after reset
    always_ff @(posedge clock)
    begin
        if (srst)
            ovp_enable <= 1'b0;
        else if (is_write && sel_ovp && wdata_ok)
            ovp_enable <= cmd_wdata[0]; // Oversized values are refused here too
    end

    // Trip latch: a clear only works once the overvoltage has gone,
    // and a trip in the clearing cycle still wins
    always_ff @(posedge clock)
    begin
        if (srst)
            ovp_tripped <= 1'b0;
        else if (ovp_enable && pins[IN_OV_SENSE])
            ovp_tripped <= 1'b1;
        else if (is_prot_clear)
            ovp_tripped <= 1'b0;
    end

    // Output is shut off while tripped; drops on the same edge that sets the trip latch
    always_ff @(posedge clock)
    begin
        if (srst)
            output_enable <= 1'b0;
        else
            output_enable <= !(ovp_tripped || (ovp_enable && pins[IN_OV_SENSE]));
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operation group
    sea_group #(.DEFINED(OPERATION_SUMMARY_BIT_DEFINED)) u_operation_summary_bit
    (
        .clock(clock),
        .srst(srst),
        .cond(operation_live_condition),
        .fall_sel(operation_falling_edge_select),
        .rise_sel(operation_rising_edge_select),
        .mask(operation_summary_mask),
        .event_read(rd_operation_summary_bit_event),
        .event_latch(operation_event_latch),
        .summary(operation_summary_bit_summary_q)
    );

    // Questionable group, same filtering
    sea_group #(.DEFINED(QUESTIONABLE_SUMMARY_BIT_DEFINED)) u_questionable_summary_bit
    (
        .clock(clock),
        .srst(srst),
        .cond(questionable_live_condition),
        .fall_sel(questionable_falling_edge_select),
        .rise_sel(questionable_rising_edge_select),
        .mask(questionable_summary_mask),
        .event_read(rd_questionable_summary_bit_event),
        .event_latch(questionable_event_latch),
        .summary(questionable_summary_bit_summary_q)
    );

    // Summary bits to the status byte
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            operation_summary_bit <= 1'b0;
            questionable_summary_bit <= 1'b0;
        end
        else
        begin
            operation_summary_bit <= operation_summary_bit_summary_q;
            questionable_summary_bit <= questionable_summary_bit_summary_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and refusal decode
    always_comb
    begin
        next_rdata = '0;
        next_error = 1'b0;
        if (is_read)
        begin
            if (sel_ovp)
                next_rdata = {15'h0000, ovp_enable};
            else if (sel_reg > REG_RISE)
                next_error = 1'b1; // Selects past the rising filter are unmapped
            else
            begin
                case (sel_reg)
                    REG_EVENT:
                        next_rdata = sel_questionable_summary_bit ? questionable_event_latch
                                              : operation_event_latch;
                    REG_COND:
                        next_rdata = sel_questionable_summary_bit ? questionable_live_condition
                                              : operation_live_condition;
                    REG_MASK:
                        next_rdata = sel_questionable_summary_bit ? questionable_summary_mask
                                              : operation_summary_mask;
                    REG_FALL:
                        next_rdata = sel_questionable_summary_bit ? questionable_falling_edge_select
                                              : operation_falling_edge_select;
                    REG_RISE:
                        next_rdata = sel_questionable_summary_bit ? questionable_rising_edge_select
                                              : operation_rising_edge_select;
                    default:
                        next_error = 1'b1;
                endcase
            end
        end
        else if (is_write)
        begin
            // Event and condition registers are read-only
            if (sel_ovp)
                next_error = !wdata_ok;
            else if (!(wr_mask || wr_fall || wr_rise))
                next_error = 1'b1;
        end
    end

    // Every command is answered one cycle after it is taken
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            rsp_valid <= 1'b0;
            rsp_error <= 1'b0;
            rsp_data <= '0;
        end
        else
        begin
            rsp_valid <= cmd_valid;
            rsp_error <= cmd_valid && next_error;
            rsp_data <= next_rdata;
        end
    end

endmodule

// [sea_top_sva.sv]
`timescale 1ns/10ps

// Answer and summary checks on the top's ports
module sea_chk
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Command and answer
    input wire logic cmd_valid,
    input wire sea_pkg::sea_op_t cmd_op,
    input wire logic [sea_pkg::SEL_W-1:0] cmd_sel,
    input wire logic [sea_pkg::REG_W-1:0] cmd_wdata,
    input wire logic rsp_valid,
    input wire logic rsp_error,
    input wire logic [sea_pkg::REG_W-1:0] rsp_data,
    // Status byte bits
    input wire logic operation_summary_bit,
    input wire logic questionable_summary_bit
);
    import sea_pkg::*;

    // One clock domain, so one default
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    // Decoded command kinds
    wire rd = cmd_valid && cmd_op == SEA_OP_READ;
    wire wr = cmd_valid && cmd_op == SEA_OP_WRITE;
    wire pre = cmd_valid && cmd_op == SEA_OP_PRESET;

    a_answer_next: assert property (cmd_valid |=> rsp_valid)
        else $error("command not answered");
    a_answer_cause: assert property (rsp_valid |-> $past(cmd_valid))
        else $error("answer without command");
    a_range_refused: assert property (wr && cmd_wdata > 16'h7FFF |=> rsp_error)
        else $error("oversized write taken");
    a_event_readonly: assert property (wr && cmd_sel[2:0] == REG_EVENT |=> rsp_error)
        else $error("event write taken");
    a_preset_clean: assert property (pre |=> rsp_valid && !rsp_error)
        else $error("preset refused");
    a_operation_summary_bit_unused: assert property
        (rd && cmd_sel < 4'h2 |=> (rsp_data & ~OPERATION_SUMMARY_BIT_DEFINED) == 16'h0000)
        else $error("unused operation bit set");
    a_questionable_summary_bit_unused: assert property
        (rd && cmd_sel inside {4'h8, 4'h9} |=> (rsp_data & ~QUESTIONABLE_SUMMARY_BIT_DEFINED) == 16'h0000)
        else $error("unused questionable bit set");
    a_top_bit_zero: assert property (rsp_valid |-> !rsp_data[15])
        else $error("bit 15 set");
    a_preset_quiet: assert property
        (pre ##1 !cmd_valid [*2] |=> !operation_summary_bit && !questionable_summary_bit)
        else $error("summary set after preset");
endmodule

bind sea_top sea_chk i_sea_chk (.*);

// [tb_sea_top.sv]
`timescale 1ns/10ps

module tb_sea_top;
    import sea_pkg::*;

    // Condition positions of the pins, in pin order
    localparam int OPOS[7] = '{0, 5, 8, 9, 10, 11, 12};
    localparam int QPOS[9] = '{1, 3, 4, 5, 8, 9, 10, 12, 14};

    // Ports and bench state
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic cmd_valid = 1'b0;
    sea_op_t cmd_op = SEA_OP_READ;
    logic [3:0] cmd_sel = 4'h0;
    logic [15:0] cmd_wdata = 16'h0000;
    logic [16:0] pins = 17'h00000;
    logic rsp_valid, rsp_error, operation_summary_bit, questionable_summary_bit, output_enable;
    logic [15:0] rsp_data, got;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;

    // Pins 0..6 operation, 7 overvoltage sense, 8..16 questionable
    sea_top i_sea_top
    (
        .*,
        .calibration_busy_flag(pins[0]), .awaiting_trigger_flag(pins[1]),
        .main_voltage_regulation_flag(pins[2]), .second_voltage_regulation_flag(pins[3]),
        .positive_current_regulation_flag(pins[4]), .negative_current_regulation_flag(pins[5]),
        .second_current_regulation_flag(pins[6]), .overvoltage_sense(pins[7]),
        .overcurrent_trip_flag(pins[8]), .local_key_flag(pins[9]),
        .overtemperature_trip_flag(pins[10]), .open_sense_lead_flag(pins[11]),
        .second_output_unregulated_flag(pins[12]), .inhibit_active_flag(pins[13]),
        .main_output_unregulated_flag(pins[14]), .second_overcurrent_trip_flag(pins[15]),
        .measurement_overload_flag(pins[16])
    );

    always #25 clock = ~clock;

    ////////////////////////////////////////
    // Condition word expected from the pins; OV trip stays off here
    function automatic logic [15:0] exp_cond(input logic [16:0] p, input int g);
        logic [15:0] e;
        e = 16'h0000;
        for (int k = 0; k < 9; k++)
            if (g == 1)
                e[QPOS[k]] = p[8 + k];
            else if (k < 7)
                e[OPOS[k]] = p[k];
        return e;
    endfunction

    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask

    // One command, answer sampled the cycle it stands
    task automatic cmd(input sea_op_t op, input logic [3:0] s, input logic [15:0] d, input logic er);
        @(posedge clock);
        #2;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_sel = s;
        cmd_wdata = d;
        @(posedge clock);
        #2;
        cmd_valid = 1'b0;
        got = rsp_data;
        chk({15'h0000, rsp_error}, {15'h0000, er}, "error");
    endtask

    task automatic chk_preset();
        for (int g = 0; g < 2; g++)
        begin
            cmd(SEA_OP_READ, {g[0], REG_MASK}, 16'h0000, 1'b0);
            chk(got, 16'h0000, "mask");
            cmd(SEA_OP_READ, {g[0], REG_FALL}, 16'h0000, 1'b0);
            chk(got, 16'h0000, "fall");
            cmd(SEA_OP_READ, {g[0], REG_RISE}, 16'h0000, 1'b0);
            chk(got, 16'h7FFF, "rise");
        end
    endtask

    // Rounds 0 and 1 pass no edge and every edge; later ones are random
    task automatic round(input int n);
        logic [16:0] op;
        logic [15:0] oc, nc, ev;
        logic [15:0] fl[2], rs[2], mk[2];
        for (int g = 0; g < 2; g++)
        begin
            fl[g] = n < 2 ? {1'b0, {15{n[0]}}} : 16'($urandom) & 16'h7FFF;
            rs[g] = n < 2 ? {1'b0, {15{n[0]}}} : 16'($urandom) & 16'h7FFF;
            mk[g] = 16'($urandom) & 16'h7FFF;
            cmd(SEA_OP_WRITE, {g[0], REG_FALL}, fl[g], 1'b0);
            cmd(SEA_OP_WRITE, {g[0], REG_RISE}, rs[g], 1'b0);
            cmd(SEA_OP_WRITE, {g[0], REG_MASK}, mk[g], 1'b0);
            cmd(SEA_OP_READ, {g[0], REG_EVENT}, 16'h0000, 1'b0);
        end
        op = pins;
        pins = 17'($urandom) & 17'h1FF7F;
        repeat (10) @(posedge clock);
        #2;
        for (int g = 0; g < 2; g++)
        begin
            oc = exp_cond(op, g);
            nc = exp_cond(pins, g);
            ev = (oc & ~nc & fl[g]) | (~oc & nc & rs[g]);
            chk(16'(g ? questionable_summary_bit : operation_summary_bit),
                16'(|(ev & mk[g])), "summary");
            cmd(SEA_OP_READ, {g[0], REG_COND}, 16'h0000, 1'b0);
            chk(got, nc, "cond");
            cmd(SEA_OP_READ, {g[0], REG_EVENT}, 16'h0000, 1'b0);
            chk(got, ev, "event");
            cmd(SEA_OP_READ, {g[0], REG_EVENT}, 16'h0000, 1'b0);
            chk(got, 16'h0000, "cleared");
        end
    endtask

    task automatic complete_run();
        if (err_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hang guard, well above the roughly 1000 cycles needed
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            err_count++;
            complete_run();
        end
    end

    initial
    begin
        void'($urandom(32'h4849407E));
        repeat (10) @(posedge clock);
        #2;
        srst = 1'b0;
        chk_preset();
        for (int i = 0; i < 24; i++)
            round(i);
        cmd(SEA_OP_WRITE, 4'h2, 16'h8000, 1'b1);
        cmd(SEA_OP_WRITE, 4'h8, 16'h0001, 1'b1);
        cmd(SEA_OP_WRITE, 4'h1, 16'h0001, 1'b1);
        cmd(SEA_OP_PRESET, 4'h0, 16'h0000, 1'b0);
        // Quiet gap so the summary-after-preset property gets exercised
        repeat (3) @(posedge clock);
        chk_preset();
        // Edge landing in the very cycle of an event read must survive it
        pins = 17'h00000;
        repeat (8) @(posedge clock);
        cmd(SEA_OP_READ, 4'h0, 16'h0000, 1'b0);
        pins[0] = 1'b1;
        repeat (4) @(posedge clock);
        cmd(SEA_OP_READ, 4'h0, 16'h0000, 1'b0);
        chk(got, 16'h0000, "read edge");
        cmd(SEA_OP_READ, 4'h0, 16'h0000, 1'b0);
        chk(got, 16'h0001, "kept edge");
        cmd(SEA_OP_WRITE, SEL_OVP_STATE, 16'h0001, 1'b0);
        pins[7] = 1'b1;
        repeat (8) @(posedge clock);
        #2;
        chk(16'(output_enable), 16'h0000, "trip");
        cmd(SEA_OP_READ, 4'h9, 16'h0000, 1'b0);
        chk(got & 16'h0001, 16'h0001, "ov flag");
        pins[7] = 1'b0;
        repeat (8) @(posedge clock);
        cmd(SEA_OP_PROT_CLEAR, 4'h0, 16'h0000, 1'b0);
        repeat (3) @(posedge clock);
        #2;
        chk(16'(output_enable), 16'h0001, "restore");
        complete_run();
    end
endmodule
